// *** common/dev_cmd_pkg.sv ***
// Purpose: shared constants and types of the device reset and idle dispatcher
// Assumes: 100 MHz clock, apb register access with 32-bit data
// Notes: all field values, offsets and timing counts live here
package dev_cmd_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int DIAG_TIME_NS = 1000;
	localparam int DIAG_CYCLES = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIAG_CNT_W = 8;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int APB_ADDR_W = 8;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam int CTRL_PKT_BIT = 0;
	localparam int CTRL_QUEUE_BIT = 1;
	localparam int CTRL_STS_LO = 4;
	localparam int CTRL_STS_HI = 6;
	localparam int CTRL_ERR_LO = 8;
	localparam int CTRL_ERR_HI = 14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0200;
	localparam int STAT_STATE_LO = 0;
	localparam int STAT_STATE_HI = 3;
	localparam int STAT_PASS_BIT = 4;
	localparam int STAT_PKT_BIT = 5;
	localparam int STAT_TYPE_LO = 8;
	localparam int STAT_TYPE_HI = 15;

	// ****************************************************************
	// frame types and register frame contents
	// ****************************************************************
	localparam logic [7:0] FIS_TYPE_REG = 8'h27;
	localparam logic [7:0] FIS_TYPE_FP_SETUP = 8'h41;
	localparam logic [7:0] SECT_VAL = 8'h01;
	localparam logic [7:0] CYL_PLAIN = 8'h00;
	localparam logic [7:0] CYL_LO_PKT = 8'h14;
	localparam logic [7:0] CYL_HI_PKT = 8'heb;
	localparam logic [7:0] DEV_HEAD_VAL = 8'h00;
	localparam logic [7:0] ERR_GOOD = 8'h01;
	localparam logic [7:0] ERR_BAD_SAFE = 8'h00;
	localparam logic [7:0] ERR_BAD_MAX = 8'h7f;
	localparam logic [7:0] STS_PKT = 8'h00;
	localparam int STS_FIELD_LO = 4;

	typedef enum logic [3:0] {
		reset_wait_state,
		init_diag_state,
		good_report_state,
		bad_report_state,
		idle_state,
		frame_classify_state,
		cmd_check_state,
		service_flag_state,
		soft_reset_entry_state
	} dev_state_t;

endpackage

// *** hdl/diag_runner.sv ***
// Purpose: hardware initialisation and power-up diagnostic sequencing
// Assumes: i_diag_ok comes from logic on the same clock
// Notes: o_done is a one-cycle pulse, o_pass holds until the next run finishes
`timescale 1ns/1ps
module diag_runner (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// control
	input wire logic i_start,
	input wire logic i_diag_ok,
	// result
	output logic o_done,
	output logic o_pass
);
	logic [dev_cmd_pkg::DIAG_CNT_W-1:0] cnt_ff;
	logic run_ff;

	// ****************************************************************
	// diagnostic timer
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end else if (i_start) begin
			cnt_ff <= dev_cmd_pkg::DIAG_CNT_W'(dev_cmd_pkg::DIAG_CYCLES - 1);
			run_ff <= 1'b1;
		end else if (run_ff) begin
			cnt_ff <= cnt_ff - 1'b1;
			run_ff <= (cnt_ff != '0);
		end
	end

	// ****************************************************************
	// result capture
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done <= 1'b0;
			o_pass <= 1'b0;
		end else begin
			o_done <= run_ff && (cnt_ff == '0) && !i_start;
			if (run_ff && (cnt_ff == '0)) begin
				o_pass <= i_diag_ok;
			end
		end
	end
endmodule // diag_runner

// *** hdl/reg_frame_fields.sv ***
// Purpose: holds the register frame contents reported after reset
// Assumes: i_load pulses once when diagnostics finish
// Notes: fields stay frozen until the next load
`timescale 1ns/1ps
module reg_frame_fields (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// load request
	input wire logic i_load,
	input wire logic i_pass,
	input wire logic i_pkt,
	input wire logic [2:0] i_sts_bits,
	input wire logic [7:0] i_bad_err,
	// frame fields
	output logic [7:0] o_sect_cnt,
	output logic [7:0] o_sect_num,
	output logic [7:0] o_cyl_lo,
	output logic [7:0] o_cyl_hi,
	output logic [7:0] o_dev_head,
	output logic [7:0] o_err,
	output logic [7:0] o_status,
	output logic o_pkt
);
	// bad error code must never read as the good code nor use bit 7
	function automatic logic [7:0] bad_err_fix(input logic [7:0] code);
		if ((code == dev_cmd_pkg::ERR_GOOD) || (code > dev_cmd_pkg::ERR_BAD_MAX)) begin
			return dev_cmd_pkg::ERR_BAD_SAFE;
		end
		return code;
	endfunction

	// ****************************************************************
	// field latch
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sect_cnt <= dev_cmd_pkg::SECT_VAL;
			o_sect_num <= dev_cmd_pkg::SECT_VAL;
			o_cyl_lo <= dev_cmd_pkg::CYL_PLAIN;
			o_cyl_hi <= dev_cmd_pkg::CYL_PLAIN;
			o_dev_head <= dev_cmd_pkg::DEV_HEAD_VAL;
			o_err <= dev_cmd_pkg::ERR_GOOD;
			o_status <= dev_cmd_pkg::STS_PKT;
			o_pkt <= 1'b0;
		end else if (i_load) begin
			o_sect_cnt <= dev_cmd_pkg::SECT_VAL;
			o_sect_num <= dev_cmd_pkg::SECT_VAL;
			o_dev_head <= dev_cmd_pkg::DEV_HEAD_VAL;
			o_pkt <= i_pkt;
			o_cyl_lo <= i_pkt ? dev_cmd_pkg::CYL_LO_PKT : dev_cmd_pkg::CYL_PLAIN;
			o_cyl_hi <= i_pkt ? dev_cmd_pkg::CYL_HI_PKT : dev_cmd_pkg::CYL_PLAIN;
			o_status <= i_pkt ? dev_cmd_pkg::STS_PKT :
				{1'b0, i_sts_bits, 4'h0};
			o_err <= i_pass ? dev_cmd_pkg::ERR_GOOD : bad_err_fix(i_bad_err);
		end
	end
endmodule // reg_frame_fields

// *** hdl/dev_reset_idle.sv ***
// Purpose: device command layer reset and idle sequencer with apb registers
// Assumes: transport signals are on i_clk; apb master on i_clk
// Notes: command protocols and soft reset protocol live outside this block
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dev_reset_idle (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// transport layer indications
	input wire logic i_comreset,
	input wire logic i_fis_rx,
	input wire logic [7:0] i_fis_type,
	input wire logic i_fis_c_bit,
	input wire logic i_soft_reset_bit,
	input wire logic i_fis_tx_done,
	input wire logic i_queue_ready,
	input wire logic i_proto_done,
	// device hardware
	input wire logic i_diag_ok,
	// transport layer requests
	output logic o_reg_tx_req,
	output logic o_sdb_tx_req,
	output logic [7:0] o_sect_cnt,
	output logic [7:0] o_sect_num,
	output logic [7:0] o_cyl_lo,
	output logic [7:0] o_cyl_hi,
	output logic [7:0] o_dev_head,
	output logic [7:0] o_err,
	output logic [7:0] o_status,
	// hand-off to outer protocols
	output logic o_cmd_check,
	output logic o_soft_reset_entry
);
	dev_cmd_pkg::dev_state_t state_ff;
	dev_cmd_pkg::dev_state_t nxt_state;
	logic [31:0] ctrl_ff;
	logic [7:0] type_ff;
	logic c_bit_ff;
	logic soft_reset_bit_ff;
	logic diag_start_ff;
	logic diag_done;
	logic diag_pass;
	logic pkt_lat;
	logic apb_acc;
	logic ctrl_hit;
	logic stat_hit;

	// ****************************************************************
	// apb slave
	// ****************************************************************
	assign apb_acc = i_psel && i_penable && o_pready;
	assign ctrl_hit = (i_paddr == dev_cmd_pkg::CTRL_ADDR);
	assign stat_hit = (i_paddr == dev_cmd_pkg::STAT_ADDR);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= i_psel && i_penable && !o_pready;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (i_psel && i_penable && !o_pready) begin
			o_pslverr <= !(ctrl_hit || stat_hit);
			o_prdata <= '0;
			if (!i_pwrite && ctrl_hit) begin
				o_prdata <= ctrl_ff;
			end else if (!i_pwrite && stat_hit) begin
				o_prdata[dev_cmd_pkg::STAT_STATE_HI:dev_cmd_pkg::STAT_STATE_LO] <= state_ff;
				o_prdata[dev_cmd_pkg::STAT_PASS_BIT] <= diag_pass;
				o_prdata[dev_cmd_pkg::STAT_PKT_BIT] <= pkt_lat;
				o_prdata[dev_cmd_pkg::STAT_TYPE_HI:dev_cmd_pkg::STAT_TYPE_LO] <= type_ff;
			end
		end else begin
			o_pslverr <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_ff <= dev_cmd_pkg::CTRL_RST;
		end else if (apb_acc && i_pwrite && ctrl_hit) begin
			ctrl_ff <= i_pwdata;
		end
	end

	// ****************************************************************
	// diagnostics and frame contents
	// ****************************************************************
	diag_runner u_diag (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_start(diag_start_ff),
		.i_diag_ok(i_diag_ok),
		.o_done(diag_done),
		.o_pass(diag_pass)
	);

	reg_frame_fields u_fields (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_load(diag_done && (state_ff == dev_cmd_pkg::init_diag_state) && !i_comreset),
		.i_pass(diag_pass),
		.i_pkt(ctrl_ff[dev_cmd_pkg::CTRL_PKT_BIT]),
		.i_sts_bits(ctrl_ff[dev_cmd_pkg::CTRL_STS_HI:dev_cmd_pkg::CTRL_STS_LO]),
		.i_bad_err(ctrl_ff[dev_cmd_pkg::CTRL_ERR_HI:dev_cmd_pkg::CTRL_ERR_LO] == 7'h00 ?
			8'h00 : {1'b0, ctrl_ff[dev_cmd_pkg::CTRL_ERR_HI:dev_cmd_pkg::CTRL_ERR_LO]}),
		.o_sect_cnt(o_sect_cnt),
		.o_sect_num(o_sect_num),
		.o_cyl_lo(o_cyl_lo),
		.o_cyl_hi(o_cyl_hi),
		.o_dev_head(o_dev_head),
		.o_err(o_err),
		.o_status(o_status),
		.o_pkt(pkt_lat)
	);

	// ****************************************************************
	// received frame capture
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			type_ff <= '0;
			c_bit_ff <= 1'b0;
			soft_reset_bit_ff <= 1'b0;
		end else if (i_fis_rx && (state_ff == dev_cmd_pkg::idle_state)) begin
			type_ff <= i_fis_type;
			c_bit_ff <= i_fis_c_bit;
			soft_reset_bit_ff <= i_soft_reset_bit;
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			dev_cmd_pkg::reset_wait_state: begin
				if (!i_comreset) begin
					nxt_state = dev_cmd_pkg::init_diag_state;
				end
			end
			dev_cmd_pkg::init_diag_state: begin
				if (diag_done && diag_pass) begin
					nxt_state = dev_cmd_pkg::good_report_state;
				end else if (diag_done) begin
					nxt_state = dev_cmd_pkg::bad_report_state;
				end
			end
			dev_cmd_pkg::good_report_state,
			dev_cmd_pkg::bad_report_state: begin
				if (i_fis_tx_done) begin
					nxt_state = dev_cmd_pkg::idle_state;
				end
			end
			dev_cmd_pkg::idle_state: begin
				if (i_fis_rx) begin
					nxt_state = dev_cmd_pkg::frame_classify_state;
				end else if (i_queue_ready && ctrl_ff[dev_cmd_pkg::CTRL_QUEUE_BIT]) begin
					nxt_state = dev_cmd_pkg::service_flag_state;
				end
			end
			dev_cmd_pkg::frame_classify_state: begin
				nxt_state = dev_cmd_pkg::idle_state;
				if (type_ff == dev_cmd_pkg::FIS_TYPE_REG) begin
					if (c_bit_ff) begin
						nxt_state = dev_cmd_pkg::cmd_check_state;
					end else if (soft_reset_bit_ff) begin
						nxt_state = dev_cmd_pkg::soft_reset_entry_state;
					end
				end
			end
			dev_cmd_pkg::service_flag_state: begin
				if (i_fis_tx_done) begin
					nxt_state = dev_cmd_pkg::idle_state;
				end
			end
			dev_cmd_pkg::cmd_check_state,
			dev_cmd_pkg::soft_reset_entry_state: begin
				if (i_proto_done) begin
					nxt_state = dev_cmd_pkg::idle_state;
				end
			end
			default: begin
				nxt_state = dev_cmd_pkg::reset_wait_state;
			end
		endcase
		if (i_comreset) begin
			nxt_state = dev_cmd_pkg::reset_wait_state;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= dev_cmd_pkg::reset_wait_state;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// request outputs
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			diag_start_ff <= 1'b0;
			o_reg_tx_req <= 1'b0;
			o_sdb_tx_req <= 1'b0;
			o_cmd_check <= 1'b0;
			o_soft_reset_entry <= 1'b0;
		end else begin
			diag_start_ff <= (nxt_state == dev_cmd_pkg::init_diag_state) &&
				(state_ff != dev_cmd_pkg::init_diag_state);
			o_reg_tx_req <= (nxt_state == dev_cmd_pkg::good_report_state) ||
				(nxt_state == dev_cmd_pkg::bad_report_state);
			o_sdb_tx_req <= (nxt_state == dev_cmd_pkg::service_flag_state);
			o_cmd_check <= (nxt_state == dev_cmd_pkg::cmd_check_state);
			o_soft_reset_entry <= (nxt_state == dev_cmd_pkg::soft_reset_entry_state);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_reset_override: assert property (i_comreset |=>
		state_ff == dev_cmd_pkg::reset_wait_state && !o_reg_tx_req && !o_cmd_check)
		else $error("comreset did not force reset wait");
	a_reset_wait_hold: assert property (
		state_ff == dev_cmd_pkg::reset_wait_state && i_comreset |=>
		state_ff == dev_cmd_pkg::reset_wait_state)
		else $error("left reset wait while comreset held");
	a_wait_to_diag: assert property (
		state_ff == dev_cmd_pkg::reset_wait_state && !i_comreset |=>
		state_ff == dev_cmd_pkg::init_diag_state && diag_start_ff)
		else $error("negation did not start diagnostics");
	a_diag_good: assert property (
		state_ff == dev_cmd_pkg::init_diag_state && diag_done && diag_pass && !i_comreset
		|=> state_ff == dev_cmd_pkg::good_report_state && o_reg_tx_req &&
		o_err == dev_cmd_pkg::ERR_GOOD)
		else $error("passing diagnostics did not report good");
	a_diag_bad: assert property (
		state_ff == dev_cmd_pkg::init_diag_state && diag_done && !diag_pass && !i_comreset
		|=> state_ff == dev_cmd_pkg::bad_report_state && o_reg_tx_req)
		else $error("failing diagnostics did not report bad");
	a_good_fields: assert property (o_reg_tx_req && !pkt_lat |->
		o_sect_cnt == dev_cmd_pkg::SECT_VAL && o_sect_num == dev_cmd_pkg::SECT_VAL &&
		o_cyl_lo == dev_cmd_pkg::CYL_PLAIN && o_cyl_hi == dev_cmd_pkg::CYL_PLAIN &&
		o_dev_head == dev_cmd_pkg::DEV_HEAD_VAL)
		else $error("plain device fields wrong");
	a_status_range: assert property (o_reg_tx_req |-> (o_status & 8'h8f) == 8'h00)
		else $error("status outside device chosen bits");
	a_packet_sig: assert property (o_reg_tx_req && pkt_lat |->
		o_cyl_lo == dev_cmd_pkg::CYL_LO_PKT && o_cyl_hi == dev_cmd_pkg::CYL_HI_PKT &&
		o_status == dev_cmd_pkg::STS_PKT && o_sect_cnt == dev_cmd_pkg::SECT_VAL)
		else $error("packet signature wrong");
	a_bad_error: assert property (state_ff == dev_cmd_pkg::bad_report_state |->
		o_err != dev_cmd_pkg::ERR_GOOD && o_err <= dev_cmd_pkg::ERR_BAD_MAX)
		else $error("bad report error code illegal");
	a_sent_idle: assert property (o_reg_tx_req && i_fis_tx_done && !i_comreset |=>
		state_ff == dev_cmd_pkg::idle_state && !o_reg_tx_req)
		else $error("report did not end in idle");
	a_rx_classify: assert property (
		state_ff == dev_cmd_pkg::idle_state && i_fis_rx && !i_comreset |=>
		state_ff == dev_cmd_pkg::frame_classify_state)
		else $error("received frame not classified");
	a_idle_hold: assert property (
		state_ff == dev_cmd_pkg::idle_state && !i_fis_rx && !i_queue_ready && !i_comreset
		|=> state_ff == dev_cmd_pkg::idle_state)
		else $error("idle left without cause");
	a_queue_gate: assert property (
		state_ff == dev_cmd_pkg::idle_state && i_queue_ready && !i_fis_rx && !i_comreset
		|=> o_sdb_tx_req == $past(ctrl_ff[dev_cmd_pkg::CTRL_QUEUE_BIT]))
		else $error("service path gating wrong");
	a_soft_reset_bit_entry: assert property (
		state_ff == dev_cmd_pkg::frame_classify_state && type_ff == dev_cmd_pkg::FIS_TYPE_REG
		&& !c_bit_ff && soft_reset_bit_ff && !i_comreset |=> o_soft_reset_entry)
		else $error("soft reset not entered");
	a_plain_reg: assert property (
		state_ff == dev_cmd_pkg::frame_classify_state && type_ff == dev_cmd_pkg::FIS_TYPE_REG
		&& !c_bit_ff && !soft_reset_bit_ff && !i_comreset |=> state_ff == dev_cmd_pkg::idle_state)
		else $error("plain register frame not idle");
	a_cmd_check: assert property (
		state_ff == dev_cmd_pkg::frame_classify_state && type_ff == dev_cmd_pkg::FIS_TYPE_REG
		&& c_bit_ff && !i_comreset |=> o_cmd_check)
		else $error("command frame not checked");
	a_other_type: assert property (
		state_ff == dev_cmd_pkg::frame_classify_state && type_ff != dev_cmd_pkg::FIS_TYPE_REG
		&& !i_comreset |=> state_ff == dev_cmd_pkg::idle_state && !o_cmd_check)
		else $error("other frame acted upon");
	a_fields_stable: assert property (o_reg_tx_req && $past(o_reg_tx_req) |->
		$stable(o_err) && $stable(o_status) && $stable(o_cyl_lo))
		else $error("fields changed during report");

	c_good_report: cover property (state_ff == dev_cmd_pkg::good_report_state ##1
		state_ff == dev_cmd_pkg::idle_state);
	c_bad_report: cover property (state_ff == dev_cmd_pkg::bad_report_state);
	c_cmd_path: cover property (o_cmd_check);
	c_soft_reset_bit_path: cover property (o_soft_reset_entry);
	c_service_path: cover property (o_sdb_tx_req);
endmodule // dev_reset_idle

// *** test/transport_model.sv ***
// Purpose: transport layer model facing the device sequencer
// Assumes: shares the device clock
// Notes: frame fields show inverted data after a receive pulse, zero before the first
`timescale 1ns/1ps
module transport_model (
	// clock
	input wire logic i_clk,
	// device requests
	input wire logic i_reg_tx_req,
	input wire logic i_sdb_tx_req,
	input wire logic i_cmd_check,
	input wire logic i_soft_reset_entry,
	// indications
	output logic o_comreset,
	output logic o_fis_rx,
	output logic [7:0] o_fis_type,
	output logic o_fis_c_bit,
	output logic o_soft_reset_bit,
	output logic o_fis_tx_done,
	output logic o_proto_done
);
	int delay = 1;
	initial begin
		o_comreset = 1'b0;
		o_fis_rx = 1'b0;
		o_fis_type = 8'h00;
		o_fis_c_bit = 1'b0;
		o_soft_reset_bit = 1'b0;
		o_fis_tx_done = 1'b0;
		o_proto_done = 1'b0;
	end
	task set_comreset(input logic v);
		@(posedge i_clk);
		o_comreset <= v;
	endtask
	task send_fis(input logic [7:0] t, input logic c, input logic s);
		@(posedge i_clk);
		o_fis_rx <= 1'b1;
		o_fis_type <= t;
		o_fis_c_bit <= c;
		o_soft_reset_bit <= s;
		@(posedge i_clk);
		o_fis_rx <= 1'b0;
		o_fis_type <= ~t;
		o_fis_c_bit <= ~c;
		o_soft_reset_bit <= ~s;
	endtask
	// answer frame requests after a stall
	always begin
		@(posedge i_clk);
		if (i_reg_tx_req === 1'b1 || i_sdb_tx_req === 1'b1) begin
			repeat (delay) @(posedge i_clk);
			o_fis_tx_done <= 1'b1;
			@(posedge i_clk);
			o_fis_tx_done <= 1'b0;
			@(posedge i_clk);
		end
	end
	// finish outer protocols after a stall
	always begin
		@(posedge i_clk);
		if (i_cmd_check === 1'b1 || i_soft_reset_entry === 1'b1) begin
			repeat (delay) @(posedge i_clk);
			o_proto_done <= 1'b1;
			@(posedge i_clk);
			o_proto_done <= 1'b0;
			@(posedge i_clk);
		end
	end
endmodule // transport_model

// *** test/tb.sv ***
// Purpose: self-checking bench of the reset and idle sequencer
// Assumes: apb access, transport model on the far side
// Notes: report fields checked while the request stands
`timescale 1ns/1ps
module tb;
	logic i_clk, i_rst_n, psel, penable, pwrite, er, pkt, dok, qrdy;
	logic [7:0] paddr, exp_err;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, cres, rx, cb, sb, txd, pd, rreq, sreq, cc, sr;
	logic [7:0] ft, sc, sn, cl, ch, dh, err, st;
	logic [3:0] flags;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [31:0] ctrl_tab [4] = '{32'h0250, 32'h0561, 32'h0170, 32'h7f01};
	logic [3:0] pass_bits = 4'b1001;
	logic [7:0] typ_tab [5] = '{8'h27, 8'h27, 8'h27, 8'h41, 8'h34};
	logic [4:0] cb_bits = 5'b10001;
	logic [4:0] sb_bits = 5'b11010;
	logic [1:0] exp_tab [5] = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
	assign flags = {rreq, sreq, cc, sr};
	dev_reset_idle dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_comreset(cres), .i_fis_rx(rx),
		.i_fis_type(ft), .i_fis_c_bit(cb), .i_soft_reset_bit(sb), .i_fis_tx_done(txd),
		.i_queue_ready(qrdy), .i_proto_done(pd), .i_diag_ok(dok), .o_reg_tx_req(rreq),
		.o_sdb_tx_req(sreq), .o_sect_cnt(sc), .o_sect_num(sn), .o_cyl_lo(cl), .o_cyl_hi(ch),
		.o_dev_head(dh), .o_err(err), .o_status(st), .o_cmd_check(cc),
		.o_soft_reset_entry(sr));
	transport_model tp (.i_clk(i_clk), .i_reg_tx_req(rreq), .i_sdb_tx_req(sreq),
		.i_cmd_check(cc), .i_soft_reset_entry(sr), .o_comreset(cres), .o_fis_rx(rx),
		.o_fis_type(ft), .o_fis_c_bit(cb), .o_soft_reset_bit(sb), .o_fis_tx_done(txd),
		.o_proto_done(pd));
	// ****************************************************************
	// tasks
	// ****************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n), 32'h2);
	endtask
	task wait_for(input int idx, input logic lvl, input int lim);
		int n;
		n = 0;
		while (flags[idx] !== lvl && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		chk(32'(flags[idx]), 32'(lvl));
	endtask
	task chk_state(input dev_cmd_pkg::dev_state_t s);
		apb(1'b0, dev_cmd_pkg::STAT_ADDR, 32'h0);
		chk(32'(rd[3:0]), 32'(s));
	endtask
	task end_sim();
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		i_rst_n = 1'b0;
		{psel, penable, pwrite, qrdy, paddr, pwdata} = '0;
		dok = 1'b1;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		apb(1'b0, dev_cmd_pkg::CTRL_ADDR, 32'h0);
		chk(rd, dev_cmd_pkg::CTRL_RST);
		apb(1'b0, 8'h08, 32'h0);
		chk({rd[31:1], er}, 32'h1);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, dev_cmd_pkg::CTRL_ADDR, ctrl_tab[k]);
			dok <= pass_bits[k];
			tp.delay = 3 * k + 1;
			tp.set_comreset(1'b1);
			tp.set_comreset(1'b0);
			repeat (30) @(posedge i_clk);
			tp.set_comreset(1'b1);
			chk_state(dev_cmd_pkg::reset_wait_state);
			tp.set_comreset(1'b0);
			wait_for(3, 1'b1, 300);
			pkt = ctrl_tab[k][0];
			exp_err = pass_bits[k] ? dev_cmd_pkg::ERR_GOOD : {1'b0, ctrl_tab[k][14:8]};
			exp_err = (exp_err == 8'h01 && !pass_bits[k]) ? dev_cmd_pkg::ERR_BAD_SAFE : exp_err;
			chk({sc, sn, dh, err}, {16'h0101, 8'h00, exp_err});
			chk(32'({cl, ch}), pkt ? 32'h14eb : 32'h0);
			chk(32'(st), pkt ? 32'h0 : {25'h0, ctrl_tab[k][6:4], 4'h0});
			dok <= ~pass_bits[k];
			wait_for(3, 1'b0, 40);
			chk(32'(err), 32'(exp_err));
			chk_state(dev_cmd_pkg::idle_state);
			chk(32'(rd[5:4]), 32'({pkt, pass_bits[k]}));
		end
		tp.delay = 6;
		for (int k = 0; k < 5; k++) begin
			tp.send_fis(typ_tab[k], cb_bits[k], sb_bits[k]);
			repeat (3) @(posedge i_clk);
			chk(32'({cc, sr}), 32'(exp_tab[k]));
			wait_for(1, 1'b0, 20);
			wait_for(0, 1'b0, 20);
			chk_state(dev_cmd_pkg::idle_state);
			chk(32'(rd[15:8]), 32'(typ_tab[k]));
		end
		qrdy <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk(32'(sreq), 32'h0);
		apb(1'b1, dev_cmd_pkg::CTRL_ADDR, 32'h0202);
		wait_for(2, 1'b1, 10);
		qrdy <= 1'b0;
		wait_for(2, 1'b0, 20);
		chk_state(dev_cmd_pkg::idle_state);
		end_sim();
	end
endmodule // tb
